/* bit_sync.sv */
// two-stage synchroniser for one asynchronous level
`timescale 1ns/10ps
module bit_sync (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic async_in,
   output logic      sync_q
);
   logic meta_q;  // first stage, read only by second stage

   // plain double flop, no logic between stages
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
endmodule

/* interval_timer.sv */
// interval timer: precounter and postcounter stepped by low-power ticks
`timescale 1ns/10ps
module interval_timer (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        lp_tick,
   input  wire logic [11:0] pre_value,
   input  wire logic [7:0]  period_value,
   input  wire logic        pending,
   output logic             applied_q,
   output logic             expiry_evt_q,
   output logic             expiry_q
);
   import wakeup_timer_pkg::*;
   logic [11:0] pre_cnt_q, pre_cnt_d;     // precounter, counts down
   logic [8:0]  post_cnt_q, post_cnt_d;   // postcounter, 1..256
   logic [11:0] pre_act_q, pre_act_d;     // active precounter setting
   logic [7:0]  per_act_q, per_act_d;     // active period setting
   logic        applied_d, evt_d, exp_d;
   logic [8:0]  post_load;                // decoded multiplier

   // next-state of counters, all steps on a low-power tick only
   always_comb begin
      pre_cnt_d  = pre_cnt_q;
      post_cnt_d = post_cnt_q;
      pre_act_d  = pre_act_q;
      per_act_d  = per_act_q;
      applied_d  = 1'b0;
      evt_d      = 1'b0;
      exp_d      = expiry_q;
      // R11 zero means the full 256
      post_load  = (per_act_q == 8'h00) ? 9'h100 : {1'b0, per_act_q};
      // R9 low-power clock paces everything
      if (lp_tick) begin
         // R18 level lasts until the next tick
         exp_d = 1'b0;
         if (pending) begin
            // R12 new setting becomes active here
            pre_act_d  = pre_value;
            per_act_d  = period_value;
            pre_cnt_d  = pre_value;
            post_cnt_d = (period_value == 8'h00) ? 9'h100 : {1'b0, period_value};
            applied_d  = 1'b1;
         end else if (pre_cnt_q <= 12'h001) begin
            // R10 precounter wrap steps the postcounter
            pre_cnt_d = pre_act_q;
            if (post_cnt_q <= 9'h001) begin
               // R14 reload and restart at once
               post_cnt_d = post_load;
               evt_d      = 1'b1;
               exp_d      = 1'b1;
            end else begin
               post_cnt_d = post_cnt_q - 9'h001;
            end
         end else begin
            pre_cnt_d = pre_cnt_q - 12'h001;
         end
      end
   end

   // register only
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pre_cnt_q    <= PRE_RST;
         post_cnt_q   <= {1'b0, PERIOD_RST};
         pre_act_q    <= PRE_RST;
         per_act_q    <= PERIOD_RST;
         applied_q    <= 1'b0;
         expiry_evt_q <= 1'b0;
         expiry_q     <= 1'b0;
      end else begin
         pre_cnt_q    <= pre_cnt_d;
         post_cnt_q   <= post_cnt_d;
         pre_act_q    <= pre_act_d;
         per_act_q    <= per_act_d;
         applied_q    <= applied_d;
         expiry_evt_q <= evt_d;
         expiry_q     <= exp_d;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_expiry_on_tick: assert property (expiry_evt_q |-> $past(lp_tick)) // R18
      else $error("expiry pulse without a low-power tick");
   a_expiry_level: assert property ($rose(expiry_q) |-> expiry_evt_q) // R14
      else $error("expiry level rose without expiry event");
endmodule

/* tb_wakeup_resume_interval_timer.sv */
// self-checking bench for the wake-up, resume and interval timer block
`timescale 1ns/10ps
module tb_wakeup_resume_interval_timer;
   import wakeup_timer_pkg::*;
   localparam int LPP   = 20;    // low-power period in core cycles, short to keep the run brief
   localparam int LIMIT = 60000; // ceiling for the whole run
   // flag bit raised by each event line, resume lines first
   localparam logic [7:0] EV_BIT [12] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h80,
                                          8'h04, 8'h08, 8'h10, 8'h20, 8'h80};
   logic        core_clk, rst_n, cyc, stb, we, ack;
   logic [11:0] adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   logic        lp_clk, lp_run, normal_mode, power_down;
   logic        irq, idle_request, wake_up, interval_expired, seen;
   logic [11:0] ev;          // event strobes, one per source
   logic [7:0]  q;
   logic [23:0] cal;
   int          err_count, n_compared, cycles, lp_cnt, n_a, n_b;

   wakeup_resume_interval_timer wakeup_resume_interval_timer_inst (
      .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .lp_clk(lp_clk), .normal_mode(normal_mode), .power_down(power_down),
      .timer_two_underflow_event(ev[0]), .rc_cal_done_event(ev[1]), .tx_buffer_empty_event(ev[2]),
      .tx_finished_event(ev[3]), .lf_buffer_full_event(ev[4]), .conversion_done_event(ev[5]),
      .crystal_switch_event(ev[6]), .pattern_zero_event(ev[7]), .pattern_one_event(ev[8]),
      .sync_match_event(ev[9]), .carrier_event(ev[10]), .watchdog_event(ev[11]),
      .irq(irq), .idle_request(idle_request), .wake_up(wake_up), .interval_expired(interval_expired));

   // core clock, 4 ns period
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // low-power clock, stands still while lp_run is low
   always @(posedge core_clk) begin
      if (lp_run) begin
         lp_cnt <= (lp_cnt == LPP / 2 - 1) ? 0 : lp_cnt + 1;
         if (lp_cnt == LPP / 2 - 1) begin
            lp_clk <= ~lp_clk;
         end
      end
   end

   // hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_count++;
         test_done();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t ns: %s seen %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic test_done;
      if (err_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // one classic cycle; ack and data are taken at the edge where ack is seen high
   task automatic wb_io(input logic w, input logic [7:0] idx, input logic [7:0] d,
                        input logic [3:0] s, input logic [11:0] with_ev, output logic [7:0] r);
      int n;
      n = 0;
      @(posedge core_clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {2'b00, idx, 2'b00};
      wdat <= {24'h000000, d};
      sel  <= s;
      ev   <= with_ev;
      do begin
         @(posedge core_clk);
         ev <= 12'h000;
         n++;
      end while (ack !== 1'b1 && n < 20);
      check({31'h0, ack}, 32'h1, "bus ack");
      r = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      wb_io(1'b1, idx, d, 4'hF, 12'h000, q);
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      wb_io(1'b0, idx, 8'h00, 4'hF, 12'h000, q);
      check({24'h0, q}, {24'h0, exp}, $sformatf("register %h", idx));
   endtask

   task automatic pulse(input int i);
      @(posedge core_clk);
      ev[i] <= 1'b1;
      @(posedge core_clk);
      ev <= 12'h000;
      repeat (2) @(posedge core_clk);
   endtask

   // counts edges until interval_expired shows the wanted level
   task automatic wait_exp(input logic lvl, output int n);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (interval_expired !== lvl && n < 6000);
   endtask

   initial begin
      {cyc, stb, we, lp_clk, lp_run, power_down, seen} = '0;
      {adr, sel, wdat, ev, lp_cnt, cycles, err_count, n_compared} = '0;
      normal_mode = 1'b1;
      rst_n = 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      // reset values, unmapped index reads zero
      rdc(IDX_WAKE_FLAG, 8'h00);
      rdc(IDX_RESUME, 8'h00);
      rdc(IDX_WAKE_MASK, 8'hFF);
      rdc(IDX_PERIOD, 8'h01);
      rdc(IDX_PRE_LO, 8'hE8);
      rdc(IDX_PRE_HI, 8'h03);
      rdc(8'h10, 8'h00);
      // each resume source, then read clears
      for (int i = 0; i < 7; i++) begin
         pulse(i);
         rdc(IDX_RESUME, EV_BIT[i]);
         rdc(IDX_RESUME, 8'h00);
      end
      // wake sources with all masks open; reserved mask bits stay one
      wr(IDX_WAKE_MASK, 8'h00);
      rdc(IDX_WAKE_MASK, 8'h42);
      for (int i = 7; i < 12; i++) begin
         pulse(i);
         rdc(IDX_WAKE_FLAG, EV_BIT[i]);
         rdc(IDX_WAKE_FLAG, 8'h00);
      end
      // masks closed: of the event lines only the watchdog passes in normal mode
      wr(IDX_WAKE_MASK, 8'hFF);
      for (int i = 7; i < 12; i++) begin
         pulse(i);
         rdc(IDX_WAKE_FLAG, (i == 11) ? 8'h80 : 8'h00);
      end
      normal_mode <= 1'b0;
      pulse(11);
      rdc(IDX_WAKE_FLAG, 8'h00);
      normal_mode <= 1'b1;
      // event in the same cycle as the clearing read is kept
      pulse(0);
      wb_io(1'b0, IDX_RESUME, 8'h00, 4'hF, 12'h001, q);
      rdc(IDX_RESUME, 8'h01);
      rdc(IDX_RESUME, 8'h00);
      // idle request dropped by a resume event; byte lane 0 gates writes
      wb_io(1'b1, IDX_CFG_ZERO, 8'h20, 4'hE, 12'h000, q);
      rdc(IDX_CFG_ZERO, 8'h00);
      wr(IDX_CFG_ZERO, 8'h20);
      check({31'h0, idle_request}, 32'h1, "idle set");
      pulse(1);
      check({31'h0, idle_request}, 32'h0, "idle clear");
      rdc(IDX_RESUME, 8'h02);
      // interrupt raised, cleared by status read, then masked; old wake and resume status first
      rdc(IDX_IRQ_STAT, 8'h03);
      wr(IDX_IRQ_MASK, 8'h02);
      pulse(2);
      check({31'h0, irq}, 32'h1, "irq high");
      rdc(IDX_IRQ_STAT, 8'h02);
      repeat (2) @(posedge core_clk);
      check({31'h0, irq}, 32'h0, "irq cleared");
      wr(IDX_IRQ_MASK, 8'h00);
      pulse(2);
      check({31'h0, irq}, 32'h0, "irq masked");
      rdc(IDX_IRQ_STAT, 8'h02);
      rdc(IDX_RESUME, 8'h04);
      // wake-up pulse from an allowed source during power-down
      wr(IDX_WAKE_MASK, 8'h00);
      power_down <= 1'b1;
      @(posedge core_clk);
      ev[10] <= 1'b1;
      @(posedge core_clk);
      ev <= 12'h000;
      repeat (4) begin
         @(posedge core_clk);
         seen = seen | (wake_up === 1'b1);
      end
      check({31'h0, seen}, 32'h1, "wake pulse");
      power_down <= 1'b0;
      rdc(IDX_WAKE_FLAG, 8'h20);
      wr(IDX_WAKE_MASK, 8'hFF);
      // new setting pends while the low-power clock stands
      wr(IDX_PRE_LO, 8'h01);
      wr(IDX_PRE_HI, 8'h00);
      wr(IDX_PERIOD, 8'h03);
      wb_io(1'b0, IDX_CFG_ONE, 8'h00, 4'hF, 12'h000, q);
      check({24'h0, q & 8'h02}, 32'h2, "pending set");
      lp_run <= 1'b1;
      repeat (3 * LPP) @(posedge core_clk);
      wb_io(1'b0, IDX_CFG_ONE, 8'h00, 4'hF, 12'h000, q);
      check({24'h0, q & 8'h02}, 32'h0, "pending clear");
      // three ticks per period, expiry held one low-power cycle
      wait_exp(1'b1, n_a);
      wait_exp(1'b0, n_a);
      check(n_a, LPP, "expiry width");
      wait_exp(1'b1, n_b);
      check(n_a + n_b, 3 * LPP, "period 3");
      rdc(IDX_WAKE_FLAG, 8'h01);
      // calibration count equals one low-power period
      for (int i = 0; i < 3; i++) begin
         wb_io(1'b0, IDX_CAL_LO + 8'(i), 8'h00, 4'hF, 12'h000, q);
         cal[8 * i +: 8] = q;
      end
      check({8'h0, cal}, LPP, "calibration");
      // period zero gives 256, timer reloads by itself
      wr(IDX_PERIOD, 8'h00);
      repeat (4 * LPP) @(posedge core_clk);
      wait_exp(1'b0, n_a);
      wait_exp(1'b1, n_a);
      wait_exp(1'b0, n_a);
      wait_exp(1'b1, n_b);
      check(n_a + n_b, 256 * LPP, "period 256");
      test_done();
   end
endmodule

/* wakeup_resume_interval_timer.sv */
// wake-up/resume flag registers, masks and interval timer behind wishbone
//
// Our own choice: register access over Wishbone.
`timescale 1ns/10ps
module wakeup_resume_interval_timer (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        lp_clk,
   input  wire logic        normal_mode,
   input  wire logic        power_down,
   input  wire logic        crystal_switch_event,
   input  wire logic        conversion_done_event,
   input  wire logic        lf_buffer_full_event,
   input  wire logic        tx_finished_event,
   input  wire logic        tx_buffer_empty_event,
   input  wire logic        rc_cal_done_event,
   input  wire logic        timer_two_underflow_event,
   input  wire logic        watchdog_event,
   input  wire logic        carrier_event,
   input  wire logic        sync_match_event,
   input  wire logic        pattern_one_event,
   input  wire logic        pattern_zero_event,
   output logic             irq,
   output logic             idle_request,
   output logic             wake_up,
   output logic             interval_expired
);
   import wakeup_timer_pkg::*;

   // register state
   logic [7:0]       wake_flag_q, wake_flag_d;       // wake source flags
   logic [7:0]       wake_mask_q, wake_mask_d;       // wake source masks
   logic [7:0]       resume_flag_q, resume_flag_d;   // resume source flags
   logic [11:0]      pre_q, pre_d;                   // precounter setting
   logic [7:0]       period_q, period_d;             // postcounter setting
   logic             pending_q, pending_d;           // setting not yet active
   logic             idle_d;                         // idle request next
   logic [2:0]       irq_stat_q, irq_stat_d;         // sticky interrupt status
   logic [2:0]       irq_mask_q, irq_mask_d;         // 1 enables a status bit
   logic             irq_d, wake_up_d;
   logic             ack_d;
   logic [31:0]      dat_d;
   logic [CAL_W-1:0] cal_run_q, cal_run_d;           // running core clock count
   logic [CAL_W-1:0] cal_q, cal_d;                   // last full lp period count
   logic             lp_sync;                        // synchronised lp clock
   logic             lp_prev_q;                      // for edge detect
   logic             lp_tick;                        // lp rising edge
   logic             applied, expiry_evt;            // from interval timer

   // bus decode
   logic             access, rd_acc, wr_acc;
   logic [7:0]       idx;
   logic [7:0]       wr_byte;
   logic [7:0]       wk_raw, wk_allow, wk_set;
   logic [7:0]       res_set;
   logic [7:0]       rd_byte;
   logic             mapped;

   // low-power clock is asynchronous: two flops before any logic
   bit_sync u_lp_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .async_in (lp_clk),
      .sync_q   (lp_sync)
   );

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         lp_prev_q <= 1'b0;
      end else begin
         lp_prev_q <= lp_sync;
      end
   end
   assign lp_tick = lp_sync & ~lp_prev_q;

   interval_timer u_timer (
      .core_clk     (core_clk),
      .rst_n        (rst_n),
      .lp_tick      (lp_tick),
      .pre_value    (pre_q),
      .period_value (period_q),
      .pending      (pending_q),
      .applied_q    (applied),
      .expiry_evt_q (expiry_evt),
      .expiry_q     (interval_expired)
   );

   // accept a request once; ack drops the cycle after it rose
   assign access  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign rd_acc  = access & ~wb_we_i;
   assign wr_acc  = access & wb_we_i & wb_sel_i[0];
   assign idx     = wb_adr_i[9:2];
   assign wr_byte = wb_dat_i[7:0];

   // R1 upper resume sources
   // R2 lower resume sources; bit 6 never set
   assign res_set = {crystal_switch_event, 1'b0, conversion_done_event, lf_buffer_full_event,
                     tx_finished_event, tx_buffer_empty_event, rc_cal_done_event,
                     timer_two_underflow_event};
   // R4 and R5 wake sources; bits 6 and 1 never set
   assign wk_raw  = {watchdog_event, 1'b0, carrier_event, sync_match_event,
                     pattern_one_event, pattern_zero_event, 1'b0, expiry_evt};
   // R6 mask 1 blocks; R7 R8 watchdog and interval forced in normal mode
   assign wk_allow = ~(wake_mask_q & ~(normal_mode ? WAKE_FORCED : 8'h00));
   assign wk_set   = wk_raw & wk_allow;

   // read mux: unmapped indices answer zero
   always_comb begin
      rd_byte = 8'h00;
      mapped  = 1'b1;
      unique case (idx)
         IDX_WAKE_FLAG: rd_byte = wake_flag_q;
         IDX_WAKE_MASK: rd_byte = wake_mask_q;
         IDX_RESUME:    rd_byte = resume_flag_q;
         IDX_PRE_LO:    rd_byte = pre_q[7:0];
         IDX_PRE_HI:    rd_byte = {4'h0, pre_q[11:8]};
         IDX_PERIOD:    rd_byte = period_q;
         IDX_CFG_ONE:   rd_byte = 8'(pending_q) << CFG_ONE_PENDING;
         IDX_CFG_ZERO:  rd_byte = 8'(idle_request) << CFG_ZERO_IDLE;
         IDX_IRQ_STAT:  rd_byte = {5'h00, irq_stat_q};
         IDX_IRQ_MASK:  rd_byte = {5'h00, irq_mask_q};
         IDX_CAL_LO:    rd_byte = cal_q[7:0];
         IDX_CAL_MID:   rd_byte = cal_q[15:8];
         IDX_CAL_HI:    rd_byte = cal_q[23:16];
         default:       mapped  = 1'b0;
      endcase
   end

   // next values of all bus-visible state but the calibration count
   always_comb begin
      wake_flag_d   = wake_flag_q;
      wake_mask_d   = wake_mask_q;
      resume_flag_d = resume_flag_q;
      pre_d         = pre_q;
      period_d      = period_q;
      pending_d     = pending_q;
      idle_d        = idle_request;
      irq_stat_d    = irq_stat_q;
      irq_mask_d    = irq_mask_q;
      ack_d         = access;
      dat_d         = wb_dat_o;
      if (access) begin
         // read data captured before any clear takes effect
         // unmapped indices answer zero on the bus
         dat_d = (wb_we_i || !mapped) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      end
      // R3 read clears resume flags
      if (rd_acc && idx == IDX_RESUME) begin
         resume_flag_d = 8'h00;
      end
      // R4 read clears wake flags
      if (rd_acc && idx == IDX_WAKE_FLAG) begin
         wake_flag_d = 8'h00;
      end
      // status read clears interrupt bits
      if (rd_acc && idx == IDX_IRQ_STAT) begin
         irq_stat_d = 3'h0;
      end
      if (wr_acc) begin
         unique case (idx)
            // R6 only documented mask bits are writable
            IDX_WAKE_MASK: wake_mask_d = (wr_byte & WAKE_MASK_WR) | ~WAKE_MASK_WR;
            IDX_PRE_LO:    pre_d[7:0]  = wr_byte;
            IDX_PRE_HI:    pre_d[11:8] = wr_byte[3:0];
            IDX_PERIOD:    period_d    = wr_byte;
            IDX_CFG_ZERO:  idle_d      = wr_byte[CFG_ZERO_IDLE];
            IDX_IRQ_MASK:  irq_mask_d  = wr_byte[2:0];
            default:       ;
         endcase
      end
      // R12 pending clears once the timer took it
      if (applied) begin
         pending_d = 1'b0;
      end
      // a fresh write after the load keeps it pending
      if (wr_acc && (idx == IDX_PERIOD || idx == IDX_PRE_LO || idx == IDX_PRE_HI)) begin
         pending_d = 1'b1;
      end
      // R16 resume event drops the idle request
      if (|res_set) begin
         idle_d = 1'b0;
      end
      // R17 hardware set wins over the read clear
      resume_flag_d = resume_flag_d | res_set;
      // R15 flag only; run state is not disturbed
      wake_flag_d   = wake_flag_d | wk_set;
      irq_stat_d    = irq_stat_d | {expiry_evt, |res_set, |wk_set};
   end

   // wake request to the state controller only while powered down
   assign wake_up_d = power_down & (|wk_set);
   assign irq_d     = |(irq_stat_d & irq_mask_d);

   // R13 count core clocks over one low-power period
   always_comb begin
      cal_run_d = cal_run_q + CAL_W'(1);
      cal_d     = cal_q;
      if (lp_tick) begin
         cal_d     = cal_run_q;
         cal_run_d = CAL_W'(1);
      end
   end

   // registers only
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wake_flag_q   <= FLAG_RST;
         wake_mask_q   <= WAKE_MASK_RST;
         resume_flag_q <= FLAG_RST;
         pre_q         <= PRE_RST;
         period_q      <= PERIOD_RST;
         pending_q     <= 1'b0;
         idle_request  <= 1'b0;
         irq_stat_q    <= 3'h0;
         irq_mask_q    <= IRQ_MASK_RST;
         irq           <= 1'b0;
         wake_up       <= 1'b0;
         wb_ack_o      <= 1'b0;
         wb_dat_o      <= 32'h0000_0000;
         cal_run_q     <= '0;
         cal_q         <= '0;
      end else begin
         wake_flag_q   <= wake_flag_d;
         wake_mask_q   <= wake_mask_d;
         resume_flag_q <= resume_flag_d;
         pre_q         <= pre_d;
         period_q      <= period_d;
         pending_q     <= pending_d;
         idle_request  <= idle_d;
         irq_stat_q    <= irq_stat_d;
         irq_mask_q    <= irq_mask_d;
         irq           <= irq_d;
         wake_up       <= wake_up_d;
         wb_ack_o      <= ack_d;
         wb_dat_o      <= dat_d;
         cal_run_q     <= cal_run_d;
         cal_q         <= cal_d;
      end
   end

   // checks beside the logic
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_resume_read_clear: assert property (rd_acc && idx == IDX_RESUME && res_set == 8'h00 |=> resume_flag_q == 8'h00) // R3
      else $error("resume flags not cleared by read");
   a_resume_set_wins: assert property (rd_acc && idx == IDX_RESUME && conversion_done_event |=> resume_flag_q[5]) // R17
      else $error("resume event lost during read");
   a_resume_bit_six: assert property (resume_flag_q[6] == 1'b0) // R3
      else $error("reserved resume bit set");
   a_xtal_sets: assert property (crystal_switch_event |=> resume_flag_q[7]) // R1
      else $error("crystal switch not recorded");
   a_underflow_sets: assert property (timer_two_underflow_event |=> resume_flag_q[0]) // R2
      else $error("timer two underflow not recorded");
   a_dog_normal: assert property (normal_mode && watchdog_event |=> wake_flag_q[7]) // R7
      else $error("watchdog blocked in normal mode");
   a_interval_wake_flag_normal: assert property (normal_mode && expiry_evt |=> wake_flag_q[0]) // R8
      else $error("interval wake blocked in normal mode");
   a_carrier_masked: assert property (wake_mask_q[5] && !(rd_acc && idx == IDX_WAKE_FLAG) |=> wake_flag_q[5] == $past(wake_flag_q[5])) // R6
      else $error("masked carrier set its flag");
   a_pattern_allowed: assert property (!wake_mask_q[3] && pattern_one_event |=> wake_flag_q[3]) // R5
      else $error("pattern one wake lost");
   a_idle_cleared: assert property (|res_set |=> !idle_request) // R16
      else $error("idle request survived resume event");
   a_pending_done: assert property (applied && !wr_acc |=> !pending_q) // R12
      else $error("pending bit not cleared");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   a_irq_level: assert property (irq == |(irq_stat_q & irq_mask_q))
      else $error("interrupt level wrong");

   c_wake_read: cover property (wake_flag_q[0] ##1 rd_acc && idx == IDX_WAKE_FLAG);
   c_expiry: cover property (expiry_evt);
   c_idle_resume: cover property (idle_request ##1 !idle_request);
   c_setting_applied: cover property (pending_q ##[1:200] !pending_q);
endmodule

/* wakeup_timer_pkg.sv */
// constants for the wake-up, resume and interval timer block
// Notes on behaviour
// R1: resume bits 7,5,4: crystal, conversion, LF buffer
// R2: resume bits 3,2,1,0: tx done, empty, cal, underflow
// R3: resume flags clear on read; bit 6 zero
// R4: wake bits 7,5,4,0 set by sources, read-clear
// R5: wake bits 3,2 pattern matches; 6,1 reserved
// R6: mask 0 allows, 1 blocks; reset all ones
// R7: watchdog mask ignored in normal mode
// R8: interval mask ignored in normal mode
// R9: interval timer clocked by 2 kHz oscillator
// R10: period is precounter ticks times postcounter
// R11: period 01h-FFh gives 1-255, 00h 256
// R12: pending bit self-clears once setting active
// R13: count system clocks per low-power period
// R14: timer reloads and restarts on expiry
// R15: interval event in run only sets flag
// R16: resume event clears idle request, records source
// R17: event during clearing read keeps flag set
// R18: expiry held one low-power clock cycle
package wakeup_timer_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_WAKE_FLAG  = 8'hC0;
   localparam logic [7:0]  IDX_WAKE_MASK  = 8'hC1;
   localparam logic [7:0]  IDX_RESUME     = 8'hD1;
   localparam logic [7:0]  IDX_PRE_LO     = 8'hBA;
   localparam logic [7:0]  IDX_PRE_HI     = 8'hBB;
   localparam logic [7:0]  IDX_PERIOD     = 8'hBC;
   localparam logic [7:0]  IDX_CFG_ONE    = 8'hE8;
   localparam logic [7:0]  IDX_CFG_ZERO   = 8'hF8;
   localparam logic [7:0]  IDX_IRQ_STAT   = 8'hF0;
   localparam logic [7:0]  IDX_IRQ_MASK   = 8'hF3;
   localparam logic [7:0]  IDX_CAL_LO     = 8'hF4;
   localparam logic [7:0]  IDX_CAL_MID    = 8'hF5;
   localparam logic [7:0]  IDX_CAL_HI     = 8'hF6;
   // field positions
   localparam int          CFG_ONE_PENDING = 1;
   localparam int          CFG_ZERO_IDLE   = 5;
   localparam int          IRQ_WAKE        = 0;
   localparam int          IRQ_RESUME      = 1;
   localparam int          IRQ_EXPIRY      = 2;
   // reset values and field masks
   localparam logic [7:0]  WAKE_MASK_RST  = 8'hFF;
   localparam logic [7:0]  WAKE_MASK_WR   = 8'hBD;
   localparam logic [7:0]  WAKE_FORCED    = 8'h81;
   localparam logic [7:0]  FLAG_RST       = 8'h00;
   localparam logic [11:0] PRE_RST        = 12'h3E8;
   localparam logic [7:0]  PERIOD_RST     = 8'h01;
   localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;
   // clock rates and calibration width
   localparam int          CORE_CLK_HZ    = 250_000_000;
   localparam int          LP_CLK_HZ      = 2000;
   localparam int          CAL_W          = 24;
endpackage
